// File: design/eis_pkg.sv
// package of constants and types for the external input sampler
// assumes one 100 MHz clock and a word-indexed register space
//
// Overview of operation
// RQ1: all eight input states are gathered into one 16-bit word, bits 0 to 7
// RQ2: input one sits in bit 0; a high input reads as 1
// RQ3: invert bit 1 flips that input's level; 0 keeps the pin level
// RQ4: inputs one to four compare their analog level against a 16-bit threshold
// RQ5: four analog levels are filtered and republished once per regulator cycle
// RQ6: 12-bit conversion results are filtered and scaled up to the 16-bit range
// RQ7: filtered levels of inputs one to four sit at indexes 170 to 173
// RQ8: inputs five to eight follow the shared encoder and serial line pins
// RQ9: bits 8 to 15 of the state word read zero; writes there are ignored
package eis_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned REG_CYCLE_NS = 10000;
  localparam int unsigned REG_CYCLE_CLKS = REG_CYCLE_NS / CLK_PERIOD_NS;
  localparam int unsigned N_INPUTS = 8;
  localparam int unsigned N_ANALOG = 4;
  localparam int unsigned ADC_BITS = 12;
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned SCALE_BITS = WORD_BITS - ADC_BITS;
  localparam int unsigned ADDR_BITS = 10;
  localparam int unsigned FILTER_SHIFT = 2;
  localparam int unsigned ANALOG_IN_LSB = 0;
  localparam int unsigned DIGITAL_IN_LSB = 4;
  localparam int unsigned IDX_INVERT = 32'h0000008C;
  localparam int unsigned IDX_THRESHOLD = 32'h0000008D;
  localparam int unsigned IDX_STATE = 32'h00000091;
  localparam int unsigned IDX_LEVEL_1 = 32'h000000AA;
  localparam int unsigned IDX_LEVEL_2 = 32'h000000AB;
  localparam int unsigned IDX_LEVEL_3 = 32'h000000AC;
  localparam int unsigned IDX_LEVEL_4 = 32'h000000AD;
  localparam logic [ADDR_BITS-1:0] ADDR_INVERT = ADDR_BITS'(IDX_INVERT * 4);
  localparam logic [ADDR_BITS-1:0] ADDR_THRESHOLD = ADDR_BITS'(IDX_THRESHOLD * 4);
  localparam logic [ADDR_BITS-1:0] ADDR_STATE = ADDR_BITS'(IDX_STATE * 4);
  localparam logic [ADDR_BITS-1:0] ADDR_LEVEL_1 = ADDR_BITS'(IDX_LEVEL_1 * 4);
  localparam logic [ADDR_BITS-1:0] ADDR_LEVEL_2 = ADDR_BITS'(IDX_LEVEL_2 * 4);
  localparam logic [ADDR_BITS-1:0] ADDR_LEVEL_3 = ADDR_BITS'(IDX_LEVEL_3 * 4);
  localparam logic [ADDR_BITS-1:0] ADDR_LEVEL_4 = ADDR_BITS'(IDX_LEVEL_4 * 4);
  localparam logic [WORD_BITS-1:0] INVERT_RESET = 16'h0000;
  localparam logic [WORD_BITS-1:0] THRESHOLD_RESET = 16'h8000;
  localparam logic [WORD_BITS-1:0] LEVEL_RESET = 16'h0000;
  localparam logic [WORD_BITS-1:0] READ_ZERO = 16'h0000;
  typedef logic [WORD_BITS-1:0] eis_word_t;
  typedef logic [ADDR_BITS-1:0] eis_addr_t;
  typedef logic [N_ANALOG-1:0][ADC_BITS-1:0] eis_raw_t;
  typedef logic [N_ANALOG-1:0][WORD_BITS-1:0] eis_levels_t;
endpackage

// File: design/eis_analog_if.sv
// carrier between the sampler top and its analog filter
// assumes both ends on the same clock
`timescale 1ns/1ps
`default_nettype none
interface eis_analog_if;
  import eis_pkg::*;
  eis_raw_t raw;
  logic [N_ANALOG-1:0] raw_valid;
  logic tick;
  eis_levels_t level;
  modport source (output raw, output raw_valid, output tick, input level);
  modport filter (input raw, input raw_valid, input tick, output level);
endinterface
`default_nettype wire

// File: design/eis_analog_filter.sv
// four-channel analog filter: scales 12-bit samples, smooths, publishes per tick
// assumes samples and tick come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module eis_analog_filter (
  input wire logic clk,
  input wire logic rst,
  eis_analog_if.filter aif
);
  import eis_pkg::*;

  typedef struct packed {
    eis_levels_t acc;
    eis_levels_t pub;
  } eis_filt_state_t;

  eis_filt_state_t st_reg;
  eis_filt_state_t st_next;
  eis_levels_t acc_upd;

  ////////////////////////////////////////////////////////////////////////
  genvar g;
  for (g = 0; g < N_ANALOG; g++) begin : g_ch
    logic [WORD_BITS-1:0] x;
    logic signed [WORD_BITS:0] diff;
    logic signed [WORD_BITS:0] step;
    logic signed [WORD_BITS:0] sum;
    // replicate top bits so full-scale 12-bit maps to 16'hFFFF
    assign x = {aif.raw[g], aif.raw[g][ADC_BITS-1 -: SCALE_BITS]}; // RQ6
    assign diff = $signed({1'b0, x}) - $signed({1'b0, st_reg.acc[g]});
    // first-order low pass; floor shift never overshoots the sample
    assign step = diff >>> FILTER_SHIFT; // RQ5
    assign sum = $signed({1'b0, st_reg.acc[g]}) + step;
    assign acc_upd[g] = aif.raw_valid[g] ? sum[WORD_BITS-1:0] : st_reg.acc[g];
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next = st_reg;
    st_next.acc = acc_upd;
    if (aif.tick) begin
      st_next.pub = st_reg.acc; // RQ5
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign aif.level = st_reg.pub;

  ////////////////////////////////////////////////////////////////////////
  AST_PUBLISH_ON_TICK: assert property (@(posedge clk) disable iff (rst) // RQ5
    aif.tick |=> st_reg.pub == $past(st_reg.acc))
    else $error("published level differs from filter state at tick");

  AST_HOLD_BETWEEN_TICKS: assert property (@(posedge clk) disable iff (rst) // RQ5
    !aif.tick |=> $stable(st_reg.pub))
    else $error("published level moved between regulator ticks");

  COV_FULL_SCALE: cover property (@(posedge clk) disable iff (rst)
    aif.raw_valid[0] && aif.raw[0] == 12'hFFF);
endmodule // eis_analog_filter
`default_nettype wire

// File: design/eis_input_sampler.sv
// top of the external input sampler: pin sync, polarity, threshold, registers
// assumes pins are asynchronous; adc samples and register port are on clk
`timescale 1ns/1ps
`default_nettype none
module eis_input_sampler #(
  parameter int unsigned REGULATOR_CLKS = eis_pkg::REG_CYCLE_CLKS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic encoder_phase_a_pin,
  input wire logic encoder_phase_b_pin,
  input wire logic serial_line_a_pin,
  input wire logic serial_line_b_pin,
  input wire eis_pkg::eis_raw_t adc_sample,
  input wire logic [eis_pkg::N_ANALOG-1:0] adc_valid,
  input wire eis_pkg::eis_addr_t reg_addr,
  input wire eis_pkg::eis_word_t reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output var eis_pkg::eis_word_t reg_rdata,
  output var logic [eis_pkg::N_INPUTS-1:0] input_state,
  output var logic regulator_tick
);
  import eis_pkg::*;

  localparam logic [WORD_BITS-1:0] TICK_LAST = WORD_BITS'(REGULATOR_CLKS - 1);
  localparam int unsigned N_PINS = N_INPUTS - N_ANALOG;

  typedef struct packed {
    logic [N_PINS-1:0] sync1;
    logic [N_PINS-1:0] sync2;
    eis_word_t invert;
    eis_word_t threshold;
    logic [N_INPUTS-1:0] state;
    eis_word_t rdata;
    logic [WORD_BITS-1:0] tick_cnt;
    logic tick;
  } eis_top_state_t;

  eis_top_state_t st_reg;
  eis_top_state_t st_next;
  logic [N_PINS-1:0] pins;
  logic [N_INPUTS-1:0] level_in;
  logic [N_ANALOG-1:0] above;

  eis_analog_if aif ();

  ////////////////////////////////////////////////////////////////////////
  // shared pins feed inputs five to eight whatever function owns them
  assign pins = {serial_line_b_pin, serial_line_a_pin, // RQ8
                 encoder_phase_b_pin, encoder_phase_a_pin};

  assign aif.raw = adc_sample;
  assign aif.raw_valid = adc_valid;
  assign aif.tick = st_reg.tick;

  eis_analog_filter u_filter (
    .clk(clk),
    .rst(rst),
    .aif(aif)
  );

  ////////////////////////////////////////////////////////////////////////
  // analog-capable inputs decide high or low from the filtered level
  genvar c;
  for (c = 0; c < N_ANALOG; c++) begin : g_cmp
    assign above[c] = aif.level[c] >= st_reg.threshold; // RQ4
  end

  // input one in bit 0, pins above the analog group
  assign level_in = {st_reg.sync2, // RQ1
                     above[N_ANALOG-1:ANALOG_IN_LSB]}; // RQ2

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next = st_reg;
    // only the four shared pins are asynchronous, so only they are synchronised
    st_next.sync1 = pins;
    st_next.sync2 = st_reg.sync1;
    st_next.state = level_in ^ st_reg.invert[N_INPUTS-1:0]; // RQ3

    // regulator cycle timebase
    st_next.tick = 1'b0;
    if (st_reg.tick_cnt == TICK_LAST) begin
      st_next.tick_cnt = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt + 16'h0001;
    end

    // writes to read-only offsets fall through and change nothing
    if (reg_write) begin
      unique case (reg_addr)
        ADDR_INVERT: st_next.invert = reg_wdata;
        ADDR_THRESHOLD: st_next.threshold = reg_wdata;
        default: ; // RQ9
      endcase
    end

    // read data stand one cycle only, zero otherwise and when unmapped
    st_next.rdata = READ_ZERO;
    if (reg_read) begin
      unique case (reg_addr)
        ADDR_INVERT: st_next.rdata = st_reg.invert;
        ADDR_THRESHOLD: st_next.rdata = st_reg.threshold;
        ADDR_STATE: st_next.rdata = {8'h00, st_reg.state}; // RQ9
        ADDR_LEVEL_1: st_next.rdata = aif.level[0]; // RQ7
        ADDR_LEVEL_2: st_next.rdata = aif.level[1];
        ADDR_LEVEL_3: st_next.rdata = aif.level[2];
        ADDR_LEVEL_4: st_next.rdata = aif.level[3];
        default: st_next.rdata = READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.invert <= INVERT_RESET;
      st_reg.threshold <= THRESHOLD_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign input_state = st_reg.state;
  assign regulator_tick = st_reg.tick;

  ////////////////////////////////////////////////////////////////////////
  AST_STATE_READ: assert property (@(posedge clk) disable iff (rst) // RQ1
    reg_read && reg_addr == ADDR_STATE
    |=> reg_rdata == {8'h00, $past(st_reg.state)})
    else $error("state word read does not show the gathered inputs");

  AST_UPPER_ZERO: assert property (@(posedge clk) disable iff (rst) // RQ9
    reg_read && reg_addr == ADDR_STATE |=> reg_rdata[15:8] == 8'h00)
    else $error("upper byte of state word not zero");

  AST_HIGH_READS_ONE: assert property (@(posedge clk) disable iff (rst) // RQ2
    st_reg.sync2[N_PINS-1] && !st_reg.invert[N_INPUTS-1]
    |=> input_state[N_INPUTS-1])
    else $error("high input with no inversion did not read 1");

  AST_INVERT: assert property (@(posedge clk) disable iff (rst) // RQ3
    ##1 input_state[N_INPUTS-1:DIGITAL_IN_LSB] ==
    $past(st_reg.sync2 ^ st_reg.invert[N_INPUTS-1:DIGITAL_IN_LSB]))
    else $error("polarity inversion not applied to digital inputs");

  AST_THRESHOLD: assert property (@(posedge clk) disable iff (rst) // RQ4
    ##1 input_state[0] == $past((aif.level[0] >= st_reg.threshold) ^ st_reg.invert[0]))
    else $error("input one not decided by the threshold");

  AST_TICK_PERIOD: assert property (@(posedge clk) disable iff (rst) // RQ5
    st_reg.tick |=> !st_reg.tick [*2])
    else $error("regulator tick repeated too soon");

  AST_LEVEL_MAP: assert property (@(posedge clk) disable iff (rst) // RQ7
    reg_read && reg_addr == ADDR_LEVEL_4 |=> reg_rdata == $past(aif.level[3]))
    else $error("fourth analog level not at its index");

  AST_LEVEL_FIRST: assert property (@(posedge clk) disable iff (rst) // RQ7
    reg_read && reg_addr == ADDR_LEVEL_1 |=> reg_rdata == $past(aif.level[0]))
    else $error("first analog level not at its index");

  AST_SHARED_PIN: assert property (@(posedge clk) disable iff (rst) // RQ8
    ##2 st_reg.sync2[N_PINS-1] == $past(serial_line_b_pin, 2))
    else $error("input eight does not follow its shared pin");

  AST_RO_WRITE: assert property (@(posedge clk) disable iff (rst) // RQ9
    reg_write && reg_addr == ADDR_STATE
    |=> $stable(st_reg.invert) && $stable(st_reg.threshold))
    else $error("write to read-only word changed a register");

  AST_RDATA_ONE_CYCLE: assert property (@(posedge clk) disable iff (rst)
    !reg_read |=> reg_rdata == READ_ZERO)
    else $error("read data held past its cycle");

  COV_INVERT_WRITE: cover property (@(posedge clk) disable iff (rst)
    reg_write && reg_addr == ADDR_INVERT ##1 reg_read && reg_addr == ADDR_STATE);
  COV_THRESHOLD_CROSS: cover property (@(posedge clk) disable iff (rst)
    !above[0] ##1 above[0]);
  COV_PIN_RISE: cover property (@(posedge clk) disable iff (rst)
    $rose(input_state[DIGITAL_IN_LSB]));
  COV_TICK: cover property (@(posedge clk) disable iff (rst) st_reg.tick);
endmodule // eis_input_sampler
`default_nettype wire

// File: verification/eis_far_side.sv
// far-side model: shared digital pins and a four-channel converter
// assumes the bench commands pin levels, codes and sample pacing on clk
`timescale 1ns/1ps
`default_nettype none
module eis_far_side (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] pin_cmd,
  input wire eis_pkg::eis_raw_t code_cmd,
  input wire logic slow,
  output var logic encoder_phase_a_pin,
  output var logic encoder_phase_b_pin,
  output var logic serial_line_a_pin,
  output var logic serial_line_b_pin,
  output var eis_pkg::eis_raw_t adc_sample,
  output var logic [eis_pkg::N_ANALOG-1:0] adc_valid
);
  import eis_pkg::*;
  logic [1:0] div_reg;
  always_comb begin
    {serial_line_b_pin, serial_line_a_pin, encoder_phase_b_pin, encoder_phase_a_pin} = pin_cmd;
  end
  // slow pacing gives one sample in four; between samples the bus carries junk
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_reg <= 2'h0;
      adc_valid <= '0;
      adc_sample <= '0;
    end else begin
      div_reg <= div_reg + 2'h1;
      adc_valid <= (slow && div_reg != 2'h0) ? 4'h0 : 4'hF;
      adc_sample <= (slow && div_reg != 2'h0) ? ~code_cmd : code_cmd;
    end
  end
endmodule // eis_far_side
`default_nettype wire

// File: verification/tb_external_input_sampler.sv
// testbench of the external input sampler, register-level tests
// assumes the far-side model drives pins and converter samples
`timescale 1ns/1ps
`default_nettype none
module tb_external_input_sampler;
  import eis_pkg::*;
  localparam int unsigned REG_CLKS = 8;
  logic clk, rst, slow, reg_write, reg_read, tick;
  logic enc_a, enc_b, ser_a, ser_b;
  logic [3:0] pin_cmd;
  logic [N_ANALOG-1:0] adc_valid;
  logic [N_INPUTS-1:0] input_state;
  eis_raw_t code_cmd, adc_sample;
  eis_addr_t reg_addr;
  eis_word_t reg_wdata, reg_rdata;
  int n_errors = 0;
  int checks_done = 0;
  eis_far_side i_far (.clk(clk), .rst(rst), .pin_cmd(pin_cmd), .code_cmd(code_cmd), .slow(slow),
    .encoder_phase_a_pin(enc_a), .encoder_phase_b_pin(enc_b), .serial_line_a_pin(ser_a),
    .serial_line_b_pin(ser_b), .adc_sample(adc_sample), .adc_valid(adc_valid));
  eis_input_sampler #(.REGULATOR_CLKS(REG_CLKS)) i_dut (.clk(clk), .rst(rst),
    .encoder_phase_a_pin(enc_a), .encoder_phase_b_pin(enc_b), .serial_line_a_pin(ser_a),
    .serial_line_b_pin(ser_b), .adc_sample(adc_sample), .adc_valid(adc_valid), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .input_state(input_state), .regulator_tick(tick));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input eis_word_t got, input eis_word_t exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input eis_addr_t a, input eis_word_t d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input eis_addr_t a, input eis_word_t exp, input string what);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, exp, what);
  endtask
  // filter may settle up to 3 below the scaled code
  task automatic lvl(input int ch, input logic [11:0] raw);
    logic [16:0] x;
    eis_word_t got;
    x = {1'b0, raw, raw[11:8]};
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= ADDR_LEVEL_1 + eis_addr_t'(4 * ch);
    @(posedge clk);
    reg_read <= 1'b0;
    #1 got = reg_rdata;
    checks_done++;
    if ((^got === 1'bx) || {1'b0, got} > x || {1'b0, got} + 17'd3 < x) begin
      n_errors++;
      $display("CHECK FAILED at %0t: level %0d got %h near %h", $time, ch, got, x);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    n_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_sim();
  end
  initial begin
    int n;
    rst = 1'b1; slow = 1'b0; reg_write = 1'b0; reg_read = 1'b0; pin_cmd = 4'h0;
    code_cmd = '0; reg_addr = '0; reg_wdata = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_INVERT, 16'h0000, "invert reset");
    rd(ADDR_THRESHOLD, 16'h8000, "threshold reset");
    rd(ADDR_STATE, 16'h0000, "state reset");
    @(posedge clk);
    #1 chk(reg_rdata, 16'h0000, "read data released");
    for (int i = 0; i < 4; i++) rd(ADDR_LEVEL_1 + eis_addr_t'(4 * i), 16'h0000, "level reset");
    rd(10'h231, 16'h0000, "unaligned read");
    rd(10'h3FC, 16'h0000, "unmapped read");
    $display("test reset done");
    for (n = 0; n < 50 && tick !== 1'b1; n++) @(posedge clk) #1;
    n = 0;
    do begin @(posedge clk) #1; n++; end while (tick !== 1'b1 && n < 50);
    chk(16'(n), 16'(REG_CLKS), "tick period");
    @(posedge clk);
    pin_cmd <= 4'b1010;
    code_cmd <= {12'h400, 12'h800, 12'h000, 12'hFFF};
    repeat (300) @(posedge clk);
    lvl(0, 12'hFFF);
    lvl(1, 12'h000);
    lvl(2, 12'h800);
    lvl(3, 12'h400);
    rd(ADDR_STATE, 16'h00A5, "state plain");
    wr(ADDR_INVERT, 16'h00F1);
    rd(ADDR_INVERT, 16'h00F1, "invert readback");
    repeat (4) @(posedge clk);
    rd(ADDR_STATE, 16'h0054, "state inverted");
    wr(ADDR_THRESHOLD, 16'h3000);
    rd(ADDR_THRESHOLD, 16'h3000, "threshold readback");
    repeat (4) @(posedge clk);
    rd(ADDR_STATE, 16'h005C, "state new threshold");
    wr(ADDR_STATE, 16'hFFFF);
    wr(ADDR_LEVEL_1, 16'h0000);
    rd(ADDR_STATE, 16'h005C, "state after write");
    lvl(0, 12'hFFF);
    $display("test fast samples done");
    @(posedge clk);
    slow <= 1'b1;
    code_cmd <= {12'hFFF, 12'h000, 12'h800, 12'h400};
    repeat (800) @(posedge clk);
    lvl(0, 12'h400);
    lvl(1, 12'h800);
    lvl(2, 12'h000);
    lvl(3, 12'hFFF);
    rd(ADDR_STATE, 16'h005A, "state slow");
    #1 chk({8'h00, input_state}, 16'h005A, "state port");
    $display("test slow samples done");
    end_sim();
  end
endmodule // tb_external_input_sampler
`default_nettype wire
